// file: src/handler_consts.svh
/*
 * Offsets, field positions, reset values and implemented-bit masks of the
 * system handler priority and control/state registers.
 * Assumes byte addresses on a 32-bit word-aligned register port.
 */
`ifndef HANDLER_CONSTS_SVH
`define HANDLER_CONSTS_SVH

// register byte addresses
`define OFF_PRI_WORD0      32'hE000ED18
`define OFF_PRI_WORD1      32'hE000ED1C
`define OFF_PRI_WORD2      32'hE000ED20
`define OFF_CTRL_STATE     32'hE000ED24
`define OFF_EVT_STATUS     32'hE000ED28
`define OFF_EVT_MASK       32'hE000ED2C

// reset values
`define RST_PRI_WORD       32'h00000000
`define RST_CTRL_STATE     32'h00000000
`define RST_EVT            32'h00000000

// implemented priority bits: top three bits of each implemented byte
`define PRI_KEEP_WORD0     32'hE0E0E0E0
`define PRI_KEEP_WORD1     32'hE0000000
`define PRI_KEEP_WORD2     32'hE0E000E0

// priority field positions (low bit of each three-bit field)
`define POS_PRI_MEMMGMT    5
`define POS_PRI_BUS        13
`define POS_PRI_USAGE      21
`define POS_PRI_SVC        29
`define POS_PRI_DBGMON     5
`define POS_PRI_PENDSV     21
`define POS_PRI_SYSTICK    29

// control/state word: fault enables
`define POS_EN_MEMMGMT     16
`define POS_EN_BUS         17
`define POS_EN_USAGE       18
// control/state word: pended flags
`define POS_PEND_USAGE     12
`define POS_PEND_MEMMGMT   13
`define POS_PEND_BUS       14
`define POS_PEND_SVC       15
// control/state word: active flags
`define POS_ACT_MEMMGMT    0
`define POS_ACT_BUS        1
`define POS_ACT_USAGE      3
`define POS_ACT_SVC        7
`define POS_ACT_DBGMON     8
`define POS_ACT_PENDSV     10
`define POS_ACT_SYSTICK    11

// implemented bits of the control/state word and of the event registers
`define CTRL_STATE_KEEP    32'h0007FD8B
`define EVT_KEEP           32'h0000FD8B

`endif

// file: src/handler_pkg.sv
/*
 * Types shared by the handler priority and state logic.
 * Assumes handler_consts.svh for all numeric values.
 */
package handler_pkg;

	typedef logic [2:0] prio_t;

	typedef struct packed {
		logic [31:0] word;
	} prio_state_t;

	typedef struct packed {
		logic [31:0] status;
		logic [31:0] mask;
	} event_state_t;

	typedef struct packed {
		logic [2:0]  fault_en;
		logic [3:0]  pended;
		logic [6:0]  active;
		logic [31:0] rdata;
	} core_state_t;

endpackage

// file: src/prio_word.sv
/*
 * One 32-bit priority word holding up to four byte-wide priority fields, as KEEP selects.
 * Assumes a one-cycle write strobe decoded by the parent.
 */
`timescale 1ns/1ps
`include "handler_consts.svh"

module prio_word #(
	parameter logic [31:0] KEEP = `PRI_KEEP_WORD0
) (
	input  wire logic        clk,     // core clock
	input  wire logic        reset_n, // synchronous reset, active low
	input  wire logic        wr,      // write strobe for this word
	input  wire logic [31:0] wdata,   // write data
	output logic      [31:0] word     // stored word, unused bits zero
);
	handler_pkg::prio_state_t s_q;
	handler_pkg::prio_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (wr) begin
			// unimplemented bits never take a value
			s_d.word = wdata & KEEP;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q.word <= `RST_PRI_WORD;
		end else begin
			s_q <= s_d;
		end
	end

	assign word = s_q.word;
endmodule

// file: src/event_regs.sv
/*
 * Sticky event status, mask and level interrupt output.
 * Assumes one-cycle event pulses and one-cycle write strobes.
 */
`timescale 1ns/1ps
`include "handler_consts.svh"

module event_regs (
	input  wire logic        clk,        // core clock
	input  wire logic        reset_n,    // synchronous reset, active low
	input  wire logic [31:0] events,     // event pulses, state word layout
	input  wire logic        status_wr,  // write-one-to-clear strobe
	input  wire logic        mask_wr,    // mask write strobe
	input  wire logic [31:0] wdata,      // write data
	output logic      [31:0] status,     // sticky status
	output logic      [31:0] mask,       // interrupt mask
	output logic             irq         // level interrupt
);
	handler_pkg::event_state_t s_q;
	handler_pkg::event_state_t s_d;
	logic [31:0] clr;

	always_comb begin
		s_d = s_q;
		clr = status_wr ? wdata : 32'h00000000;
		// a new event in the clearing cycle is kept
		s_d.status = ((s_q.status & ~clr) | events) & `EVT_KEEP;
		if (mask_wr) begin
			s_d.mask = wdata & `EVT_KEEP;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q.status <= `RST_EVT;
			s_q.mask   <= `RST_EVT;
		end else begin
			s_q <= s_d;
		end
	end

	assign status = s_q.status;
	assign mask   = s_q.mask;
	assign irq    = |(s_q.status & s_q.mask);
endmodule

// file: src/handler_regs.sv
/*
 * System handler priority words and handler control/state word behind a
 * plain register port, with sticky events and one interrupt line.
 * Assumes the exception logic drives set/clear pulses on the core clock
 * and that reads return data in the cycle after the read strobe.
 */
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "handler_consts.svh"

module handler_regs (
	input  wire logic        clk,              // core clock, 25 MHz
	input  wire logic        reset_n,          // sync reset, active low
	input  wire logic [31:0] addr,             // register byte address
	input  wire logic [31:0] wdata,            // write data
	input  wire logic        wr,               // write strobe
	input  wire logic        rd,               // read strobe
	output logic      [31:0] rdata,            // read data, cycle after rd
	output logic             irq,              // level interrupt
	input  wire logic [3:0]  pend_set,         // hw pended set pulses
	input  wire logic [3:0]  pend_clr,         // hw pended clear pulses
	input  wire logic [6:0]  act_set,          // hw active set pulses
	input  wire logic [6:0]  act_clr,          // hw active clear pulses
	output logic             usage_fault_enable,   // usage fault enable
	output logic             bus_fault_enable,     // bus fault enable
	output logic             memmgmt_fault_enable, // memmgmt enable
	output logic [3:0]       pended,           // usage,mem,bus,svc pended
	output logic [6:0]       active,           // active flags
	output logic             service_call_pending, // svc pended flag
	output logic             system_tick_active,   // tick active flag
	output logic             debug_monitor_active, // monitor active flag
	output handler_pkg::prio_t prio_memmgmt,   // memmgmt priority
	output handler_pkg::prio_t prio_bus,       // bus fault priority
	output handler_pkg::prio_t prio_usage,     // usage fault priority
	output handler_pkg::prio_t prio_svc,       // service call priority
	output handler_pkg::prio_t prio_dbgmon,    // debug monitor priority
	output handler_pkg::prio_t prio_pendsv,    // pending service priority
	output handler_pkg::prio_t prio_systick    // system tick priority
);
	// pended index: 0 usage, 1 memmgmt, 2 bus, 3 svc
	localparam int PEND_POS [4] = '{
		`POS_PEND_USAGE,
		`POS_PEND_MEMMGMT,
		`POS_PEND_BUS,
		`POS_PEND_SVC
	};
	// active index: 0 mem, 1 bus, 2 usage, 3 svc, 4 mon, 5 pendsv, 6 tick
	localparam int ACT_POS [7] = '{
		`POS_ACT_MEMMGMT,
		`POS_ACT_BUS,
		`POS_ACT_USAGE,
		`POS_ACT_SVC,
		`POS_ACT_DBGMON,
		`POS_ACT_PENDSV,
		`POS_ACT_SYSTICK
	};
	// enable index: 0 memmgmt, 1 bus, 2 usage
	localparam int EN_POS [3] = '{
		`POS_EN_MEMMGMT,
		`POS_EN_BUS,
		`POS_EN_USAGE
	};
	localparam logic [31:0] PRI_OFF [3] = '{
		`OFF_PRI_WORD0,
		`OFF_PRI_WORD1,
		`OFF_PRI_WORD2
	};
	localparam logic [31:0] PRI_KEEP [3] = '{
		`PRI_KEEP_WORD0,
		`PRI_KEEP_WORD1,
		`PRI_KEEP_WORD2
	};

	handler_pkg::core_state_t s_q;
	handler_pkg::core_state_t s_d;

	logic [31:0] pri_word [3];
	logic [2:0]  pri_hit;
	logic        ctrl_hit;
	logic        status_hit;
	logic        mask_hit;
	logic [31:0] state_word;
	logic [31:0] evt_word;
	logic [31:0] evt_status;
	logic [31:0] evt_mask;
	logic        evt_irq;

	// address decode
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pri_hit[i] = (addr == PRI_OFF[i]);
		end
		ctrl_hit   = (addr == `OFF_CTRL_STATE);
		status_hit = (addr == `OFF_EVT_STATUS);
		mask_hit   = (addr == `OFF_EVT_MASK);
	end

	// one word per generate step; each keeps only the implemented top three bits of its bytes
	for (genvar g = 0; g < 3; g++) begin : g_pri
		prio_word #(
			.KEEP (PRI_KEEP[g])
		) u_word (
			.clk     (clk),
			.reset_n (reset_n),
			.wr      (wr && pri_hit[g]),
			.wdata   (wdata),
			.word    (pri_word[g])
		);
	end

	// priority fields handed to the priority resolver
	assign prio_usage   = pri_word[0][`POS_PRI_USAGE +: 3];
	assign prio_bus     = pri_word[0][`POS_PRI_BUS +: 3];
	assign prio_memmgmt = pri_word[0][`POS_PRI_MEMMGMT +: 3];
	assign prio_svc     = pri_word[1][`POS_PRI_SVC +: 3];
	assign prio_dbgmon  = pri_word[2][`POS_PRI_DBGMON +: 3];
	assign prio_pendsv  = pri_word[2][`POS_PRI_PENDSV +: 3];
	assign prio_systick = pri_word[2][`POS_PRI_SYSTICK +: 3];

	// pack stored flags into the state word layout
	always_comb begin
		state_word = 32'h00000000;
		for (int i = 0; i < 3; i++) begin
			state_word[EN_POS[i]] = s_q.fault_en[i];
		end
		for (int i = 0; i < 4; i++) begin
			state_word[PEND_POS[i]] = s_q.pended[i];
		end
		for (int i = 0; i < 7; i++) begin
			state_word[ACT_POS[i]] = s_q.active[i];
		end
	end

	// events are the hardware set pulses, in state word layout
	always_comb begin
		evt_word = 32'h00000000;
		for (int i = 0; i < 4; i++) begin
			evt_word[PEND_POS[i]] = pend_set[i];
		end
		for (int i = 0; i < 7; i++) begin
			evt_word[ACT_POS[i]] = act_set[i];
		end
	end

	event_regs u_events (
		.clk       (clk),
		.reset_n   (reset_n),
		.events    (evt_word),
		.status_wr (wr && status_hit),
		.mask_wr   (wr && mask_hit),
		.wdata     (wdata),
		.status    (evt_status),
		.mask      (evt_mask),
		.irq       (evt_irq)
	);

	// next state: software write, then hardware clear, then hardware set,
	// so a hardware set in the same cycle as a clear is never lost
	always_comb begin
		s_d = s_q;
		if (wr && ctrl_hit) begin
			// only implemented positions are taken from the write data
			for (int i = 0; i < 3; i++) begin
				s_d.fault_en[i] = wdata[EN_POS[i]];
			end
			for (int i = 0; i < 4; i++) begin
				s_d.pended[i] = wdata[PEND_POS[i]];
			end
			for (int i = 0; i < 7; i++) begin
				s_d.active[i] = wdata[ACT_POS[i]];
			end
		end
		s_d.pended = (s_d.pended & ~pend_clr) | pend_set;
		s_d.active = (s_d.active & ~act_clr) | act_set;

		// read data stands only in the cycle after the strobe
		s_d.rdata = 32'h00000000;
		if (rd) begin
			if (pri_hit[0]) begin
				s_d.rdata = pri_word[0];
			end else if (pri_hit[1]) begin
				s_d.rdata = pri_word[1];
			end else if (pri_hit[2]) begin
				s_d.rdata = pri_word[2];
			end else if (ctrl_hit) begin
				s_d.rdata = state_word & `CTRL_STATE_KEEP;
			end else if (status_hit) begin
				s_d.rdata = evt_status;
			end else if (mask_hit) begin
				s_d.rdata = evt_mask;
			end else begin
				// unmapped addresses read zero and never stall
				s_d.rdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q.fault_en <= 3'h0;
			s_q.pended   <= 4'h0;
			s_q.active   <= 7'h00;
			s_q.rdata    <= 32'h00000000;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign irq   = evt_irq;

	assign memmgmt_fault_enable = s_q.fault_en[0];
	assign bus_fault_enable     = s_q.fault_en[1];
	assign usage_fault_enable   = s_q.fault_en[2];
	assign pended               = s_q.pended;
	assign active               = s_q.active;
	assign service_call_pending = s_q.pended[3];
	assign debug_monitor_active = s_q.active[4];
	assign system_tick_active   = s_q.active[6];
endmodule

// file: testbench/handler_regs_monitor.sv
/* port checker for handler_regs: priority fields, unused bits, state word.
   assumes a bind into handler_regs on one clock domain. */
`timescale 1ns/1ps
`include "handler_consts.svh"
module handler_regs_monitor (
	input wire logic               clk,                // core clock
	input wire logic               reset_n,            // sync reset
	input wire logic [31:0]        addr,               // address
	input wire logic [31:0]        wdata,              // write data
	input wire logic               wr,                 // write strobe
	input wire logic               rd,                 // read strobe
	input wire logic [31:0]        rdata,              // read data
	input wire logic [3:0]         pend_set,           // pend set
	input wire logic [6:0]         act_set,            // active set
	input wire logic [6:0]         act_clr,            // active clear
	input wire logic               usage_fault_enable, // enable
	input wire logic               bus_fault_enable,   // enable
	input wire logic [3:0]         pended,             // pended flags
	input wire logic [6:0]         active,             // active flags
	input wire handler_pkg::prio_t prio_memmgmt,       // priority
	input wire handler_pkg::prio_t prio_bus,           // priority
	input wire handler_pkg::prio_t prio_usage          // priority
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence w0_s;
		wr && addr == `OFF_PRI_WORD0;
	endsequence
	sequence rd_s(a);
		rd && addr == a;
	endsequence
	usage_prio_a: assert property (w0_s |=> prio_usage == $past(wdata[23:21]))
		else $error("usage priority not stored");
	bus_prio_a: assert property (w0_s |=> prio_bus == $past(wdata[15:13]))
		else $error("bus priority not stored");
	mem_prio_a: assert property (w0_s |=> prio_memmgmt == $past(wdata[7:5]))
		else $error("memmgmt priority not stored");
	word0_unused_a: assert property (rd_s(`OFF_PRI_WORD0) |=> (rdata & ~`PRI_KEEP_WORD0) == 32'h0)
		else $error("word0 unused bits not zero");
	word1_unused_a: assert property (rd_s(`OFF_PRI_WORD1) |=> rdata[28:0] == 29'h0)
		else $error("word1 unused bits not zero");
	unmapped_read_a: assert property (rd_s(32'hE000ED30) |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	fault_en_a: assert property (wr && addr == `OFF_CTRL_STATE |=> {usage_fault_enable, bus_fault_enable} == $past(wdata[18:17]))
		else $error("fault enables not stored");
	pend_set_a: assert property (pend_set[0] |=> pended[0])
		else $error("pended flag not set");
	act_clear_a: assert property (act_clr[0] && !act_set[0] && !wr |=> !active[0])
		else $error("active flag not cleared");
endmodule
bind handler_regs handler_regs_monitor mon (.clk, .reset_n, .addr, .wdata,
	.wr, .rd, .rdata, .pend_set, .act_set, .act_clr, .usage_fault_enable,
	.bus_fault_enable, .pended, .active, .prio_memmgmt, .prio_bus,
	.prio_usage);

// file: testbench/handler_regs_test.sv
/* self-checking bench for handler_regs over its register port.
   assumes the design answers reads one cycle after the strobe. */
`timescale 1ns/1ps
`include "handler_consts.svh"
module handler_regs_test;
	logic clk = 0, reset_n = 0, wr = 0, rd = 0;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
	logic irq, ufe, bfe, mfe, scp, sta, dma;
	logic [3:0] pend_set = 4'h0, pend_clr = 4'h0, pended;
	logic [6:0] act_set = 7'h0, act_clr = 7'h0, active;
	handler_pkg::prio_t pm, pb, pu, ps, pd, pp, pt;
	int n_errors = 0, n_tests = 0, cycles = 0;
	handler_regs dut (.clk(clk), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
		.pend_set(pend_set), .pend_clr(pend_clr), .act_set(act_set),
		.act_clr(act_clr), .usage_fault_enable(ufe), .bus_fault_enable(bfe),
		.memmgmt_fault_enable(mfe), .pended(pended), .active(active),
		.service_call_pending(scp), .system_tick_active(sta),
		.debug_monitor_active(dma), .prio_memmgmt(pm), .prio_bus(pb),
		.prio_usage(pu), .prio_svc(ps), .prio_dbgmon(pd), .prio_pendsv(pp),
		.prio_systick(pt));
	always #20 clk = ~clk;
	task automatic close_out;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// generous ceiling: the whole run is about fifty cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			close_out;
		end
	end
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(logic [31:0] a, logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(string what, logic [31:0] a, logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(what, exp, rdata);
	endtask
	task automatic pulse(logic [3:0] ps_, logic [3:0] pc_, logic [6:0] as_,
		logic [6:0] ac_);
		@(posedge clk);
		{pend_set, pend_clr, act_set, act_clr} <= {ps_, pc_, as_, ac_};
		@(posedge clk);
		{pend_set, pend_clr, act_set, act_clr} <= 22'h0;
		#1;
	endtask
	task automatic t_reset;
		rd_chk("word0", `OFF_PRI_WORD0, 32'h0);
		rd_chk("state", `OFF_CTRL_STATE, 32'h0);
		check("irq", 32'h0, {31'h0, irq});
	endtask
	task automatic t_prio;
		wr_reg(`OFF_PRI_WORD0, 32'hFFFFFFFF);
		wr_reg(`OFF_PRI_WORD1, 32'hFFFFFFFF);
		wr_reg(`OFF_PRI_WORD2, 32'hFFFFFFFF);
		rd_chk("word0", `OFF_PRI_WORD0, 32'hE0E0E0E0);
		rd_chk("word1", `OFF_PRI_WORD1, 32'hE0000000);
		rd_chk("word2", `OFF_PRI_WORD2, 32'hE0E000E0);
		check("svc prio", 32'h7, {29'h0, ps});
		check("tick prio", 32'h7, {29'h0, pt});
		check("pendsv prio", 32'h7, {29'h0, pp});
		check("monitor prio", 32'h7, {29'h0, pd});
		wr_reg(`OFF_PRI_WORD0, 32'h5FBF7F5F);
		rd_chk("word0", `OFF_PRI_WORD0, 32'h40A06040);
		check("usage prio", 32'h5, {29'h0, pu});
		check("bus prio", 32'h3, {29'h0, pb});
		check("mem prio", 32'h2, {29'h0, pm});
	endtask
	task automatic t_state;
		wr_reg(`OFF_CTRL_STATE, 32'hFFFFFFFF);
		rd_chk("state", `OFF_CTRL_STATE, 32'h0007FD8B);
		check("enables", 32'h7, {29'h0, ufe, bfe, mfe});
		check("svc pend", 32'h1, {31'h0, scp});
		check("monitor act", 32'h1, {31'h0, dma});
		check("active", 32'h7F, {25'h0, active});
		wr_reg(`OFF_CTRL_STATE, 32'h0);
		rd_chk("state", `OFF_CTRL_STATE, 32'h0);
		wr_reg(32'hE000ED30, 32'hFFFFFFFF);
		rd_chk("unmapped", 32'hE000ED30, 32'h0);
	endtask
	task automatic t_events;
		wr_reg(`OFF_EVT_MASK, 32'h00001000);
		pulse(4'h1, 4'h1, 7'h40, 7'h0);
		check("irq on", 32'h1, {31'h0, irq});
		check("pended", 32'h1, {28'h0, pended});
		check("tick act", 32'h1, {31'h0, sta});
		rd_chk("state", `OFF_CTRL_STATE, 32'h00001800);
		rd_chk("status", `OFF_EVT_STATUS, 32'h00001800);
		wr_reg(`OFF_EVT_STATUS, 32'h00001000);
		#1 check("irq off", 32'h0, {31'h0, irq});
		pulse(4'h0, 4'h1, 7'h0, 7'h40);
		rd_chk("state", `OFF_CTRL_STATE, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		t_prio;
		t_state;
		t_events;
		close_out;
	end
endmodule
